// ==== verilog/exs_pkg.sv ====
// Package of timing constants and types for the execute stage timing controller
package exs_pkg;

  // ----------------------------------------------------------------
  // Instruction timing classes
  // ----------------------------------------------------------------
  typedef enum logic [2:0]
  {
    EXS_SINGLE = 3'h0,
    EXS_MULT   = 3'h1,
    EXS_STORE  = 3'h2,
    EXS_XMULT  = 3'h3,
    EXS_LOAD   = 3'h4,
    EXS_BRANCH = 3'h5,
    EXS_NOP    = 3'h6
  } exs_class_type;

  // ----------------------------------------------------------------
  // Phase numbers and delay slots
  // ----------------------------------------------------------------
  localparam int EXS_NUM_PHASES = 5;
  localparam logic [2:0] EXS_WB_SINGLE = 3'h1;
  localparam logic [2:0] EXS_WB_MULT = 3'h2;
  localparam logic [2:0] EXS_WB_XMULT = 3'h4;
  localparam logic [2:0] EXS_WB_LOAD = 3'h5;
  localparam logic [2:0] EXS_SLOTS_SINGLE = 3'h0;
  localparam logic [2:0] EXS_SLOTS_MULT = 3'h1;
  localparam logic [2:0] EXS_SLOTS_STORE = 3'h0;
  localparam logic [2:0] EXS_SLOTS_XMULT = 3'h3;
  localparam logic [2:0] EXS_SLOTS_LOAD = 3'h4;
  localparam logic [2:0] EXS_SLOTS_BRANCH = 3'h5;

endpackage

// ==== verilog/exs_slot.sv ====
// One slot of the execute timing pipe: holds one instruction in flight
`timescale 1ns/1ps
module exs_slot #(
  parameter int DW = 32,
  parameter int AW = 16,
  parameter int RW = 4
)
(
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_valid,
  input wire exs_pkg::exs_class_type i_class,
  input wire logic [RW-1:0] i_dest,
  input wire logic [DW-1:0] i_data,
  input wire logic [AW-1:0] i_addr,
  output logic o_valid,
  output exs_pkg::exs_class_type o_class,
  output logic [RW-1:0] o_dest,
  output logic [DW-1:0] o_data,
  output logic [AW-1:0] o_addr
);

  typedef struct packed
  {
    logic valid;
    exs_pkg::exs_class_type cls;
    logic [RW-1:0] dest;
    logic [DW-1:0] data;
    logic [AW-1:0] addr;
  } exs_slot_type;

  exs_slot_type state;
  exs_slot_type next_state;

  // Load the slot from the previous phase
  always_comb
  begin
    next_state = state;
    next_state.valid = i_valid;
    next_state.cls = i_class;
    next_state.dest = i_dest;
    next_state.data = i_data;
    next_state.addr = i_addr;
    if (!i_rst_n)
    begin
      next_state = '0;
    end
  end

  // Slot register
  always_ff @(posedge i_sys_clk)
  begin
    state <= next_state;
  end

  assign o_valid = state.valid;
  assign o_class = state.cls;
  assign o_dest = state.dest;
  assign o_data = state.data;
  assign o_addr = state.addr;

endmodule // exs_slot

// ==== verilog/exs_execute.sv ====
// Execute stage timing controller: sequences instructions through five execute phases
`timescale 1ns/1ps
module exs_execute #(
  parameter int DW = 32,
  parameter int AW = 16,
  parameter int RW = 4,
  parameter int PW = 32
)
(
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // Issue port: one instruction per lane per packet
  input wire logic i_issue_valid,
  input wire exs_pkg::exs_class_type i_issue_class,
  input wire logic i_issue_cond,
  input wire logic [RW-1:0] i_issue_dest,
  input wire logic [DW-1:0] i_issue_result,
  input wire logic [AW-1:0] i_issue_addr,
  input wire logic [DW-1:0] i_issue_store_data,
  input wire logic [RW-1:0] i_issue_ptr_reg,
  input wire logic [AW-1:0] i_issue_ptr_next,
  input wire logic [PW-1:0] i_issue_target,
  // Second lane: a store in the same packet as the first lane
  input wire logic i_pair_store_valid,
  input wire logic [AW-1:0] i_pair_store_addr,
  input wire logic [DW-1:0] i_pair_store_data,
  // Data memory
  output logic o_mem_req,
  output logic o_mem_we,
  output logic [AW-1:0] o_mem_addr,
  output logic [DW-1:0] o_mem_wdata,
  output logic o_mem_rd_strobe,
  output logic o_mem_wr_strobe,
  input wire logic [DW-1:0] i_mem_rdata,
  // Program fetch
  output logic o_pg_redirect,
  output logic [PW-1:0] o_pg_target,
  // Register file write ports
  output logic o_ptr_we,
  output logic [RW-1:0] o_ptr_waddr,
  output logic [AW-1:0] o_ptr_wdata,
  output logic o_single_we,
  output logic [RW-1:0] o_single_waddr,
  output logic [DW-1:0] o_single_wdata,
  output logic o_mult_we,
  output logic [RW-1:0] o_mult_waddr,
  output logic [DW-1:0] o_mult_wdata,
  output logic o_xmult_we,
  output logic [RW-1:0] o_xmult_waddr,
  output logic [DW-1:0] o_xmult_wdata,
  output logic o_load_we,
  output logic [RW-1:0] o_load_waddr,
  output logic [DW-1:0] o_load_wdata,
  // Phase-one unit busy flag and delay slots of the issued instruction
  output logic o_unit_busy,
  output logic [2:0] o_delay_slots
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed
  {
    logic ptr_we;
    logic [RW-1:0] ptr_waddr;
    logic [AW-1:0] ptr_wdata;
    logic single_we;
    logic [RW-1:0] single_waddr;
    logic [DW-1:0] single_wdata;
    logic mult_we;
    logic [RW-1:0] mult_waddr;
    logic [DW-1:0] mult_wdata;
    logic xmult_we;
    logic [RW-1:0] xmult_waddr;
    logic [DW-1:0] xmult_wdata;
    logic redirect;
    logic [PW-1:0] target;
    logic pair_e2;
    logic pair_e3;
    logic mem_req;
    logic mem_we;
    logic [AW-1:0] mem_addr;
    logic [DW-1:0] mem_wdata;
    logic rd_strobe;
    logic wr_strobe;
    logic load_we;
    logic [RW-1:0] load_waddr;
    logic [DW-1:0] load_wdata;
  } exs_ctl_type;

  exs_ctl_type state;
  exs_ctl_type next_state;

  localparam int EXS_N = exs_pkg::EXS_NUM_PHASES - 1;

  // Phase slots: index 1 is execute_phase_two ... index 4 is execute_phase_five
  logic [EXS_N:1] slot_valid;
  exs_pkg::exs_class_type slot_class [EXS_N:1];
  logic [RW-1:0] slot_dest [EXS_N:1];
  logic [DW-1:0] slot_data [EXS_N:1];
  logic [AW-1:0] slot_addr [EXS_N:1];

  // ----------------------------------------------------------------
  // Execute phase one decode
  // ----------------------------------------------------------------
  logic e1_live;
  logic e1_mult;
  logic e1_store;
  logic e1_xmult;
  logic e1_load;
  logic e1_single;
  logic e1_branch;
  logic e1_pair;
  logic [DW-1:0] e1_carry;

  // Only true-condition, non-nop instructions go past phase one
  assign e1_live = i_issue_valid && i_issue_cond && (i_issue_class != exs_pkg::EXS_NOP);
  assign e1_single = e1_live && (i_issue_class == exs_pkg::EXS_SINGLE);
  assign e1_mult = e1_live && (i_issue_class == exs_pkg::EXS_MULT);
  assign e1_store = e1_live && (i_issue_class == exs_pkg::EXS_STORE);
  assign e1_xmult = e1_live && (i_issue_class == exs_pkg::EXS_XMULT);
  assign e1_load = e1_live && (i_issue_class == exs_pkg::EXS_LOAD);
  assign e1_branch = e1_live && (i_issue_class == exs_pkg::EXS_BRANCH);
  // A paired store shares the single memory port, so it only joins a load of the same word
  assign e1_pair = e1_load && i_pair_store_valid && (i_pair_store_addr == i_issue_addr);
  // Store carries its data, a load the data of its paired store, others their result
  assign e1_carry = e1_store ? i_issue_store_data : (e1_load ? i_pair_store_data : i_issue_result);

  // Delay slots reported per class; nop holds no unit
  always_comb
  begin
    o_delay_slots = exs_pkg::EXS_SLOTS_SINGLE;
    o_unit_busy = i_issue_valid && (i_issue_class != exs_pkg::EXS_NOP);
    case (i_issue_class)
      exs_pkg::EXS_MULT: o_delay_slots = exs_pkg::EXS_SLOTS_MULT;
      exs_pkg::EXS_STORE: o_delay_slots = exs_pkg::EXS_SLOTS_STORE;
      exs_pkg::EXS_XMULT: o_delay_slots = exs_pkg::EXS_SLOTS_XMULT;
      exs_pkg::EXS_LOAD: o_delay_slots = exs_pkg::EXS_SLOTS_LOAD;
      exs_pkg::EXS_BRANCH: o_delay_slots = exs_pkg::EXS_SLOTS_BRANCH;
      default: o_delay_slots = exs_pkg::EXS_SLOTS_SINGLE;
    endcase
  end

  // ----------------------------------------------------------------
  // Phase slots for multicycle classes
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 1; g <= EXS_N; g++)
    begin : gen_slot
      logic in_valid;
      exs_pkg::exs_class_type in_class;
      logic [RW-1:0] in_dest;
      logic [DW-1:0] in_data;
      logic [AW-1:0] in_addr;
      if (g == 1)
      begin : gen_head
        // Single cycle and branch finish in phase one
        assign in_valid = e1_mult || e1_store || e1_xmult || e1_load;
        assign in_class = i_issue_class;
        assign in_dest = i_issue_dest;
        assign in_data = e1_carry;
        assign in_addr = i_issue_addr;
      end
      else
      begin : gen_tail
        // Each class leaves the pipe after its last phase
        assign in_valid = slot_valid[g-1] &&
          !(g - 1 >= 1 && slot_class[g-1] == exs_pkg::EXS_MULT) &&
          !(g - 1 >= 2 && slot_class[g-1] == exs_pkg::EXS_STORE) &&
          !(g - 1 >= 3 && slot_class[g-1] == exs_pkg::EXS_XMULT);
        assign in_class = slot_class[g-1];
        assign in_dest = slot_dest[g-1];
        assign in_data = slot_data[g-1];
        assign in_addr = slot_addr[g-1];
      end
      exs_slot #(
        .DW(DW),
        .AW(AW),
        .RW(RW)
      ) u_slot (
        .i_sys_clk(i_sys_clk),
        .i_rst_n(i_rst_n),
        .i_valid(in_valid),
        .i_class(in_class),
        .i_dest(in_dest),
        .i_data(in_data),
        .i_addr(in_addr),
        .o_valid(slot_valid[g]),
        .o_class(slot_class[g]),
        .o_dest(slot_dest[g]),
        .o_data(slot_data[g]),
        .o_addr(slot_addr[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic p3_store;
  logic p3_load;
  logic p5_load;

  // Phase three sits in slot 2, phase five in slot 4
  assign p3_store = slot_valid[2] && (slot_class[2] == exs_pkg::EXS_STORE);
  assign p3_load = slot_valid[2] && (slot_class[2] == exs_pkg::EXS_LOAD);
  assign p5_load = slot_valid[4] && (slot_class[4] == exs_pkg::EXS_LOAD);

  always_comb
  begin
    next_state = state;
    // Pointer update written in phase one, usable next packet
    next_state.ptr_we = (e1_load || e1_store) && (i_issue_ptr_reg != '0);
    next_state.ptr_waddr = i_issue_ptr_reg;
    next_state.ptr_wdata = i_issue_ptr_next;
    // Single-cycle result lands at the end of phase one
    next_state.single_we = e1_single;
    next_state.single_waddr = i_issue_dest;
    next_state.single_wdata = i_issue_result;
    // Multiply result lands at the end of phase two
    next_state.mult_we = slot_valid[1] && (slot_class[1] == exs_pkg::EXS_MULT);
    next_state.mult_waddr = slot_dest[1];
    next_state.mult_wdata = slot_data[1];
    // Extended multiply result lands at the end of phase four
    next_state.xmult_we = slot_valid[3] && (slot_class[3] == exs_pkg::EXS_XMULT);
    next_state.xmult_waddr = slot_dest[3];
    next_state.xmult_wdata = slot_data[3];
    // Branch target is registered and steers address generation in the cycle after issue
    next_state.redirect = e1_branch;
    next_state.target = i_issue_target;
    // A paired store rides along with its load up to the access phase
    next_state.pair_e2 = e1_pair;
    next_state.pair_e3 = state.pair_e2;
    // Phase three is the access; one op per phase keeps issue order as access order
    next_state.mem_req = p3_store || p3_load;
    next_state.mem_we = p3_store || (p3_load && state.pair_e3);
    next_state.mem_addr = slot_addr[2];
    next_state.mem_wdata = slot_data[2];
    next_state.rd_strobe = p3_load;
    next_state.wr_strobe = p3_store || (p3_load && state.pair_e3);
    // Data at the core boundary is written to the register in phase five
    next_state.load_we = p5_load;
    next_state.load_waddr = slot_dest[4];
    next_state.load_wdata = i_mem_rdata;
    if (!i_rst_n)
    begin
      next_state = '0;
    end
  end

  // State register
  always_ff @(posedge i_sys_clk)
  begin
    state <= next_state;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Memory ops are in order: a store one packet ahead lands before the load reads
  assign o_mem_req = state.mem_req;
  assign o_mem_we = state.mem_we;
  assign o_mem_addr = state.mem_addr;
  assign o_mem_wdata = state.mem_wdata;
  // Read and write strobes of a paired access are raised in the same cycle
  assign o_mem_rd_strobe = state.rd_strobe;
  assign o_mem_wr_strobe = state.wr_strobe;
  assign o_pg_redirect = state.redirect;
  assign o_pg_target = state.target;
  assign o_ptr_we = state.ptr_we;
  assign o_ptr_waddr = state.ptr_waddr;
  assign o_ptr_wdata = state.ptr_wdata;
  // All write ports are independent so same-cycle finishers commit together
  assign o_single_we = state.single_we;
  assign o_single_waddr = state.single_waddr;
  assign o_single_wdata = state.single_wdata;
  // Multiply result written at end of phase two
  assign o_mult_we = state.mult_we;
  assign o_mult_waddr = state.mult_waddr;
  assign o_mult_wdata = state.mult_wdata;
  // Extended multiply written at end of phase four
  assign o_xmult_we = state.xmult_we;
  assign o_xmult_waddr = state.xmult_waddr;
  assign o_xmult_wdata = state.xmult_wdata;
  assign o_load_we = state.load_we;
  assign o_load_waddr = state.load_waddr;
  assign o_load_wdata = state.load_wdata;

endmodule // exs_execute

// ==== test/exs_execute_chk.sv ====
// Checker of execute stage timing seen at the controller ports
`timescale 1ns/1ps
module exs_execute_chk #(
  parameter int DW = 32,
  parameter int AW = 16,
  parameter int RW = 4,
  parameter int PW = 32
)
(
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_issue_valid,
  input wire exs_pkg::exs_class_type i_issue_class,
  input wire logic i_issue_cond,
  input wire logic [DW-1:0] i_issue_result,
  input wire logic [AW-1:0] i_issue_addr,
  input wire logic [RW-1:0] i_issue_ptr_reg,
  input wire logic [PW-1:0] i_issue_target,
  input wire logic o_mem_req,
  input wire logic o_mem_we,
  input wire logic [AW-1:0] o_mem_addr,
  input wire logic o_mem_rd_strobe,
  input wire logic o_mem_wr_strobe,
  input wire logic o_pg_redirect,
  input wire logic [PW-1:0] o_pg_target,
  input wire logic o_ptr_we,
  input wire logic o_single_we,
  input wire logic [DW-1:0] o_single_wdata,
  input wire logic o_mult_we,
  input wire logic [DW-1:0] o_mult_wdata,
  input wire logic o_xmult_we,
  input wire logic o_load_we,
  input wire logic o_unit_busy,
  input wire logic [2:0] o_delay_slots
);
  // ----------------------------------------------------------------
  // Phase timing of each class
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rst_n);

  // Issue of one class with a true condition
  sequence s_take(exs_pkg::exs_class_type c);
    i_issue_valid && i_issue_cond && i_issue_class == c;
  endsequence
  sequence s_mem_read;
    o_mem_req && o_mem_rd_strobe;
  endsequence

  a_single_write: assert property (s_take(exs_pkg::EXS_SINGLE) |=>
    o_single_we && o_single_wdata == $past(i_issue_result)) else $error("single write late");
  a_mult_write: assert property (s_take(exs_pkg::EXS_MULT) |-> ##2
    o_mult_we && o_mult_wdata == $past(i_issue_result, 2)) else $error("mult write wrong");
  a_xmult_write: assert property (s_take(exs_pkg::EXS_XMULT) |-> ##4 o_xmult_we)
    else $error("xmult write wrong");
  a_load_steps: assert property (s_take(exs_pkg::EXS_LOAD) ##0 i_issue_ptr_reg != 0
    |=> o_ptr_we ##2 s_mem_read ##2 o_load_we) else $error("load steps wrong");
  a_store_access: assert property (s_take(exs_pkg::EXS_STORE) |-> ##3 o_mem_req && o_mem_we
    && o_mem_wr_strobe && o_mem_addr == $past(i_issue_addr, 3)) else $error("store access wrong");
  a_branch_target: assert property (s_take(exs_pkg::EXS_BRANCH) |=>
    o_pg_redirect && o_pg_target == $past(i_issue_target)) else $error("branch redirect wrong");
  a_false_quiet: assert property (i_issue_valid && !i_issue_cond &&
    i_issue_class == exs_pkg::EXS_LOAD |-> ##3 !o_mem_req ##2 !o_load_we) else $error("false load acted");
  a_nop_idle: assert property (i_issue_valid && i_issue_class == exs_pkg::EXS_NOP |->
    !o_unit_busy) else $error("nop took a unit");
  a_store_slots: assert property (s_take(exs_pkg::EXS_STORE) |->
    o_delay_slots == exs_pkg::EXS_SLOTS_STORE) else $error("store slots wrong");
endmodule // exs_execute_chk

bind exs_execute exs_execute_chk #(.DW(DW), .AW(AW), .RW(RW), .PW(PW)) exs_execute_chk_inst (
  .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_issue_valid(i_issue_valid),
  .i_issue_class(i_issue_class), .i_issue_cond(i_issue_cond), .i_issue_result(i_issue_result),
  .i_issue_addr(i_issue_addr), .i_issue_ptr_reg(i_issue_ptr_reg), .i_issue_target(i_issue_target),
  .o_mem_req(o_mem_req), .o_mem_we(o_mem_we), .o_mem_addr(o_mem_addr), .o_mem_rd_strobe(o_mem_rd_strobe),
  .o_mem_wr_strobe(o_mem_wr_strobe), .o_pg_redirect(o_pg_redirect), .o_pg_target(o_pg_target),
  .o_ptr_we(o_ptr_we), .o_single_we(o_single_we), .o_single_wdata(o_single_wdata),
  .o_mult_we(o_mult_we), .o_mult_wdata(o_mult_wdata), .o_xmult_we(o_xmult_we),
  .o_load_we(o_load_we), .o_unit_busy(o_unit_busy), .o_delay_slots(o_delay_slots));

// ==== test/exs_dmem_model.sv ====
// Data memory model answering the execute stage
`timescale 1ns/1ps
module exs_dmem_model #(
  parameter int DW = 32,
  parameter int AW = 16
)
(
  input wire logic i_sys_clk,
  input wire logic i_mem_req,
  input wire logic [AW-1:0] i_mem_addr,
  input wire logic [DW-1:0] i_mem_wdata,
  input wire logic i_mem_rd_strobe,
  input wire logic i_mem_wr_strobe,
  output logic [DW-1:0] o_mem_rdata
);
  logic [DW-1:0] mem [256];
  // Preload every word with a pattern of its own address
  initial
  begin
    for (int i = 0; i < 256; i++)
      mem[i] = DW'(32'hC0DE0000 + i);
    o_mem_rdata = '0;
  end
  // A read takes the old word before a write at the same edge; idle data toggles
  always @(posedge i_sys_clk)
  begin
    if (i_mem_req && i_mem_rd_strobe)
      o_mem_rdata <= mem[i_mem_addr[7:0]];
    else
      o_mem_rdata <= ~o_mem_rdata;
    if (i_mem_req && i_mem_wr_strobe)
      mem[i_mem_addr[7:0]] <= i_mem_wdata;
  end
endmodule // exs_dmem_model

// ==== test/exs_execute_tb_top.sv ====
// Self-checking bench of the execute stage timing controller
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin n_tests++; if ((got) !== (exp)) begin errors++; \
  $display("[ERR] %s expected %0h seen %0h", nm, exp, got); end end
module exs_execute_tb_top;
  logic clk, rst_n, iv, ic, pv, mreq, mwe, mrd, mwr, redir, pwe, swe, mwe2, xwe, lwe, busy;
  exs_pkg::exs_class_type cls;
  logic [3:0] dest, preg, pwa, swa, mwa, xwa, lwa;
  logic [15:0] addr, pnext, paddr, maddr, pwd;
  logic [31:0] res, sd, tgt, pdata, mwd, rdata, pgt, swd, mwd2, xwd, lwd;
  logic [2:0] slots;
  int errors = 0;
  int n_tests = 0;
  exs_execute exs_execute_inst (.i_sys_clk(clk), .i_rst_n(rst_n), .i_issue_valid(iv), .i_issue_class(cls),
    .i_issue_cond(ic), .i_issue_dest(dest), .i_issue_result(res), .i_issue_addr(addr),
    .i_issue_store_data(sd), .i_issue_ptr_reg(preg), .i_issue_ptr_next(pnext), .i_issue_target(tgt),
    .i_pair_store_valid(pv), .i_pair_store_addr(paddr), .i_pair_store_data(pdata), .o_mem_req(mreq),
    .o_mem_we(mwe), .o_mem_addr(maddr), .o_mem_wdata(mwd), .o_mem_rd_strobe(mrd), .o_mem_wr_strobe(mwr),
    .i_mem_rdata(rdata), .o_pg_redirect(redir), .o_pg_target(pgt), .o_ptr_we(pwe), .o_ptr_waddr(pwa),
    .o_ptr_wdata(pwd), .o_single_we(swe), .o_single_waddr(swa), .o_single_wdata(swd), .o_mult_we(mwe2),
    .o_mult_waddr(mwa), .o_mult_wdata(mwd2), .o_xmult_we(xwe), .o_xmult_waddr(xwa), .o_xmult_wdata(xwd),
    .o_load_we(lwe), .o_load_waddr(lwa), .o_load_wdata(lwd), .o_unit_busy(busy), .o_delay_slots(slots));
  exs_dmem_model exs_dmem_model_inst (.i_sys_clk(clk), .i_mem_req(mreq), .i_mem_addr(maddr),
    .i_mem_wdata(mwd), .i_mem_rd_strobe(mrd), .i_mem_wr_strobe(mwr), .o_mem_rdata(rdata));

  // ----------------------------------------------------------------
  // Drivers and scenarios
  // ----------------------------------------------------------------
  // Issue one instruction for one cycle; v sets dest, pointer, result, data and target
  task automatic iss(input exs_pkg::exs_class_type c, input logic [31:0] v, input logic [15:0] a, input logic k);
    @(posedge clk);
    iv <= 1'b1;
    cls <= c;
    ic <= k;
    {dest, preg} <= {2{v[3:0]}};
    {res, sd, tgt} <= {3{v}};
    addr <= a;
    pnext <= a + 16'h0001;
  endtask
  task automatic idle();
    @(posedge clk);
    iv <= 1'b0;
    pv <= 1'b0;
  endtask
  // Bounded wait for the load write-back, returning its data
  task automatic wait_load(output logic [31:0] d);
    #1;
    for (int i = 0; i < 10 && lwe !== 1'b1; i++)
    begin
      @(posedge clk);
      #1;
    end
    d = lwd;
  endtask
  // Four classes finishing in one cycle
  task automatic t_writeback();
    iss(exs_pkg::EXS_LOAD, 32'h00000005, 16'h0020, 1'b1);
    iss(exs_pkg::EXS_XMULT, 32'h11111116, 16'h0000, 1'b1);
    iss(exs_pkg::EXS_NOP, 32'h00000000, 16'h0000, 1'b1);
    iss(exs_pkg::EXS_MULT, 32'h22222227, 16'h0000, 1'b1);
    iss(exs_pkg::EXS_SINGLE, 32'h33333338, 16'h0000, 1'b1);
    #1;
    `CHK("mult early", 1'b0, mwe2)
    idle();
    #1;
    `CHK("all we", 4'hF, {swe, mwe2, xwe, lwe})
    `CHK("single", 32'h33333338, swd)
    `CHK("mult", 32'h22222227, mwd2)
    `CHK("xmult", 32'h11111116, xwd)
    `CHK("write regs", {4'h8, 4'h7, 4'h6}, {swa, mwa, xwa})
    `CHK("load", {4'h5, 32'hC0DE0020}, {lwa, lwd})
  endtask
  // Load and store ordering on one word
  task automatic t_mem_order();
    logic [31:0] d;
    iss(exs_pkg::EXS_LOAD, 32'h00000001, 16'h0010, 1'b1);
    iss(exs_pkg::EXS_STORE, 32'hAAAA0001, 16'h0010, 1'b1);
    idle();
    wait_load(d);
    `CHK("load then store", 32'hC0DE0010, d)
    iss(exs_pkg::EXS_STORE, 32'hBBBB0002, 16'h0010, 1'b1);
    iss(exs_pkg::EXS_LOAD, 32'h00000002, 16'h0010, 1'b1);
    idle();
    wait_load(d);
    `CHK("store then load", 32'hBBBB0002, d)
    iss(exs_pkg::EXS_LOAD, 32'h00000003, 16'h0010, 1'b1);
    pv <= 1'b1;
    paddr <= 16'h0010;
    pdata <= 32'hCCCC0003;
    idle();
    wait_load(d);
    `CHK("same packet old", 32'hBBBB0002, d)
    iss(exs_pkg::EXS_LOAD, 32'h00000004, 16'h0010, 1'b1);
    idle();
    wait_load(d);
    `CHK("same packet new", 32'hCCCC0003, d)
  endtask
  // Delay slots per class, no-op, branch, pointer and false condition
  task automatic t_misc();
    logic [2:0] exp_slots [6] = '{3'h0, 3'h1, 3'h0, 3'h3, 3'h4, 3'h5};
    logic seen;
    for (int i = 0; i < 6; i++)
    begin
      iss(exs_pkg::exs_class_type'(i), 32'h00000009, 16'h0040, 1'b1);
      #1;
      `CHK("slots", {1'b1, exp_slots[i]}, {busy, slots})
    end
    iss(exs_pkg::EXS_NOP, 32'h00000000, 16'h0000, 1'b1);
    #1;
    `CHK("nop busy", 1'b0, busy)
    iss(exs_pkg::EXS_BRANCH, 32'h0000ABC0, 16'h0000, 1'b1);
    idle();
    #1;
    `CHK("redirect", {1'b1, 32'h0000ABC0}, {redir, pgt})
    iss(exs_pkg::EXS_LOAD, 32'h00000007, 16'h0050, 1'b1);
    idle();
    #1;
    `CHK("pointer", {1'b1, 4'h7, 16'h0051}, {pwe, pwa, pwd})
    repeat (6) idle();
    iss(exs_pkg::EXS_LOAD, 32'h00000008, 16'h0060, 1'b0);
    iss(exs_pkg::EXS_SINGLE, 32'h00000008, 16'h0000, 1'b0);
    idle();
    seen = 1'b0;
    repeat (6)
    begin
      #1;
      seen = seen | mreq | lwe | swe;
      @(posedge clk);
    end
    `CHK("false quiet", 1'b0, seen)
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Clock, reset, main sequence and watchdog
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial
  begin
    {rst_n, iv, ic, pv, dest, preg, addr, pnext, paddr, res, sd, tgt, pdata} = '0;
    cls = exs_pkg::EXS_NOP;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    t_writeback();
    t_mem_order();
    t_misc();
    wrap_up();
  end
  initial
  begin
    repeat (3000) @(posedge clk);
    errors++;
    wrap_up();
  end
endmodule // exs_execute_tb_top
